/* File: dpr_cfg.svh */
// Offsets, field positions, reset values and sizes of the dual-port memory block
`ifndef DPR_CFG_SVH
`define DPR_CFG_SVH
`define DPR_CAPACITY 4608
`define DPR_DATA_BITS 4096
`define DPR_WORDS 128
`define DPR_DATA_W 36
`define DPR_ADDR_W 12
`define DPR_LANES 4
`define DPR_LANE_W 9
`define DPR_BYTE_W 8
`define DPR_ROW_BITS 32
`define DPR_MASK_MIN_W 16
`define DPR_PAR_WC 3
`define DPR_MAX_WC 5
`define DPR_TDP_MAX_WC 4
`define DPR_OFS_CTRL 5'h00
`define DPR_OFS_SHIFT 5'h04
`define DPR_OFS_STATUS 5'h08
`define DPR_OFS_INIT_ADDR 5'h0c
`define DPR_OFS_INIT_DATA 5'h10
`define DPR_OFS_INIT_PAR 5'h14
`define DPR_CTRL_MODE 0
`define DPR_CTRL_WC_A 4
`define DPR_CTRL_PAR_A 7
`define DPR_CTRL_WC_B 8
`define DPR_CTRL_PAR_B 11
`define DPR_CTRL_INSEL_A 12
`define DPR_CTRL_INSEL_B 13
`define DPR_CTRL_OUTSEL_A 14
`define DPR_CTRL_OUTSEL_B 15
`define DPR_CTRL_BYP_A 16
`define DPR_CTRL_BYP_B 17
`define DPR_SHIFT_LEN 0
`define DPR_SHIFT_LEN_W 13
`define DPR_SHIFT_TAPS 16
`define DPR_SHIFT_TAPS_W 6
`define DPR_STAT_ERR 0
`define DPR_STAT_FULL 1
`define DPR_STAT_EMPTY 2
`define DPR_STAT_COUNT 16
`define DPR_CTRL_RST 32'h0000_0000
`define DPR_SHIFT_RST 32'h0001_0001
`endif

/* File: dpr_pkg.sv */
// Types shared by the dual-port memory block
package dpr_pkg;
	typedef enum logic [2:0] {
		DPR_TDP = 3'h0,
		DPR_SDP = 3'h1,
		DPR_SP = 3'h2,
		DPR_FIFO = 3'h3,
		DPR_ROM = 3'h4,
		DPR_SHIFT = 3'h5
	} dpr_mode_e;
	typedef logic [11:0] dpr_addr_t;
	typedef logic [35:0] dpr_word_t;
endpackage

/* File: dpr_ram.sv */
// Configurable 4,608-bit dual-port memory block with an Avalon-MM configuration slave
//
// Behaviour
// RULE1 - Storage totals 4,608 bits, parity bits included.
// RULE2 - Modes: true dual-port, simple dual-port, single-port, FIFO, ROM, shift register.
// RULE3 - Port shapes 4Kx1, 2Kx2, 1Kx4, 512x8/9, 256x16/18, 128x32/36.
// RULE4 - True dual-port mode forbids the 128-deep 32/36-bit shape.
// RULE5 - Simple dual-port: widths may differ, never mixing parity and plain groups.
// RULE6 - True dual-port: A and B shapes differ only within one group.
// RULE7 - Shift register width times length times taps stays within 4,608 bits.
// RULE8 - Byte masking only at 16, 18, 32, 36 bit write widths.
// RULE9 - Unmasked bytes keep their stored value during a masked write.
// RULE10 - Mask bit n gates data bits 9n+8 to 9n.
// RULE11 - Any combination of mask bits is accepted, none or all included.
// RULE12 - Plain 16/32-bit widths use 8-bit lanes in the same order.
// RULE13 - Input and output registers each follow either of two clocks.
// RULE14 - Only output register may be bypassed; all inputs always registered.
// RULE15 - RAM and ROM contents can be preloaded at configuration time.
// RULE16 - Fabric supplies clock, clock enable, read/write enable and clear per port.
// RULE17 - Shift mode reads old data then writes, advancing one place per cycle.
// RULE18 - One extra parity-capable bit is stored per byte.
// RULE19 - Enabled port writes when read/write enable is high, else reads.
// RULE20 - Clear zeroes the port output register, memory untouched.
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/10ps
`include "dpr_cfg.svh"
module dpr_ram #(
	parameter int DATA_W = `DPR_DATA_W,
	parameter int ADDR_W = `DPR_ADDR_W,
	parameter int WORDS = `DPR_WORDS
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic clk0_en,
	input wire logic clk1_en,
	input wire logic ce_a,
	input wire logic rdwr_a,
	input wire logic clr_a,
	input wire logic [ADDR_W-1:0] addr_a,
	input wire logic [3:0] bmask_a,
	input wire logic [DATA_W-1:0] wdata_a,
	output logic [DATA_W-1:0] rdata_a,
	input wire logic ce_b,
	input wire logic rdwr_b,
	input wire logic clr_b,
	input wire logic [ADDR_W-1:0] addr_b,
	input wire logic [3:0] bmask_b,
	input wire logic [DATA_W-1:0] wdata_b,
	output logic [DATA_W-1:0] rdata_b
);
	function automatic int width_of(input logic [2:0] wc, input logic par);
		return par ? (`DPR_LANE_W << (int'(wc) - `DPR_PAR_WC)) : (1 << wc);
	endfunction

	function automatic logic [6:0] word_of(input logic [2:0] wc, input logic par,
		input logic [11:0] addr);
		int lanes;
		lanes = par ? int'(addr) * (width_of(wc, par) / `DPR_LANE_W)
			: ((int'(addr) << wc) / `DPR_BYTE_W);
		return 7'(lanes / `DPR_LANES);
	endfunction

	// Plain data skips the ninth bit of each lane; parity shapes fill whole lanes
	function automatic logic [5:0] bit_of(input logic [2:0] wc, input logic par,
		input logic [11:0] addr, input int i);
		int s;
		if (par)
		begin
			s = (int'(addr) * (width_of(wc, par) / `DPR_LANE_W)) % `DPR_LANES;
			return 6'(s * `DPR_LANE_W + i); // RULE18
		end
		s = ((int'(addr) << wc) % `DPR_ROW_BITS) + i;
		return 6'((s / `DPR_BYTE_W) * `DPR_LANE_W + s % `DPR_BYTE_W); // RULE12
	endfunction

	function automatic dpr_pkg::dpr_word_t read_of(input logic [2:0] wc, input logic par,
		input logic [11:0] addr, input dpr_pkg::dpr_word_t word);
		dpr_pkg::dpr_word_t r;
		r = '0;
		for (int i = 0; i < `DPR_DATA_W; i++)
			if (i < width_of(wc, par))
				r[i] = word[bit_of(wc, par, addr, i)];
		return r;
	endfunction

	function automatic dpr_pkg::dpr_word_t wmask_of(input logic [2:0] wc, input logic par,
		input logic [11:0] addr, input logic [3:0] gate);
		dpr_pkg::dpr_word_t m;
		m = '0;
		for (int i = 0; i < `DPR_DATA_W; i++)
			if (i < width_of(wc, par))
				m[bit_of(wc, par, addr, i)] =
					gate[2'(par ? i / `DPR_LANE_W : i / `DPR_BYTE_W)]; // RULE10 RULE11
		return m;
	endfunction

	function automatic dpr_pkg::dpr_word_t wval_of(input logic [2:0] wc, input logic par,
		input logic [11:0] addr, input dpr_pkg::dpr_word_t d);
		dpr_pkg::dpr_word_t v;
		v = '0;
		for (int i = 0; i < `DPR_DATA_W; i++)
			if (i < width_of(wc, par))
				v[bit_of(wc, par, addr, i)] = d[i];
		return v;
	endfunction

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (be[b])
				r[b*`DPR_BYTE_W +: `DPR_BYTE_W] = nw[b*`DPR_BYTE_W +: `DPR_BYTE_W];
		return r;
	endfunction

	dpr_pkg::dpr_word_t mem_q [WORDS]; // RULE1
	logic [31:0] ctrl_q, shift_q, rdata_q, rdata_d;
	logic [6:0] init_addr_q;
	logic [3:0] init_par_q;
	logic ack_q, bus_wr, init_we;
	dpr_pkg::dpr_mode_e mode;
	logic [2:0] wc_a, wc_b;
	logic par_a, par_b, cfg_err;
	int wid_a, wid_b, depth_a, tap_len, tap_cnt, sr_len;
	logic ie_a, ie_b, oe_a, oe_b, go_a_q, go_b_q, we_a_q, we_b_q;
	dpr_pkg::dpr_addr_t addr_a_q, addr_b_q, ea_a, ea_b, wptr_q, rptr_q, sr_ptr_q, ta;
	logic [3:0] bm_a_q, bm_b_q, bea, beb;
	dpr_pkg::dpr_word_t wd_a_q, wd_b_q, wm_a, wm_b, nw_a, nw_b, rx_a, rx_b, sr_taps, tap_w;
	dpr_pkg::dpr_word_t rd_a_q, rd_b_q, out_a_q, out_b_q;
	logic [6:0] wa_a, wa_b;
	logic wr_a, wr_b, rd_a_en, rd_b_en, push, pop, full, empty;
	logic [12:0] count_q;
	default clocking dpr_cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	assign mode = dpr_pkg::dpr_mode_e'(ctrl_q[`DPR_CTRL_MODE +: 3]); // RULE2
	assign wc_a = ctrl_q[`DPR_CTRL_WC_A +: 3];
	assign wc_b = ctrl_q[`DPR_CTRL_WC_B +: 3];
	assign par_a = ctrl_q[`DPR_CTRL_PAR_A];
	assign par_b = ctrl_q[`DPR_CTRL_PAR_B];

	// Shape legality per mode; an illegal set-up blocks every port read and write, preload writes still land
	always_comb
	begin
		wid_a = width_of(wc_a, par_a);
		wid_b = width_of(wc_b, par_b);
		depth_a = (par_a ? `DPR_CAPACITY : `DPR_DATA_BITS) / wid_a;
		tap_len = int'(shift_q[`DPR_SHIFT_LEN +: `DPR_SHIFT_LEN_W]);
		tap_cnt = int'(shift_q[`DPR_SHIFT_TAPS +: `DPR_SHIFT_TAPS_W]);
		sr_len = tap_len * tap_cnt;
		cfg_err = wc_a > `DPR_MAX_WC || wc_b > `DPR_MAX_WC
			|| (par_a && wc_a < `DPR_PAR_WC) || (par_b && wc_b < `DPR_PAR_WC); // RULE3
		unique case (mode)
			dpr_pkg::DPR_TDP:
				cfg_err = cfg_err || wc_a > `DPR_TDP_MAX_WC || wc_b > `DPR_TDP_MAX_WC // RULE4
					|| par_a != par_b; // RULE6
			dpr_pkg::DPR_SDP:
				cfg_err = cfg_err || par_a != par_b; // RULE5
			dpr_pkg::DPR_SP, dpr_pkg::DPR_ROM:
				cfg_err = cfg_err;
			dpr_pkg::DPR_FIFO:
				cfg_err = cfg_err || wc_a != wc_b || par_a != par_b;
			dpr_pkg::DPR_SHIFT:
				cfg_err = cfg_err || sr_len == 0 || sr_len > depth_a
					|| wid_a * sr_len > `DPR_CAPACITY || wid_a * tap_cnt > DATA_W; // RULE7
			default:
				cfg_err = 1'b1;
		endcase
	end

	// Avalon slave: one wait cycle, then the answer
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	assign avs_readdata = rdata_q;
	assign bus_wr = avs_write && ack_q;
	assign init_we = bus_wr && avs_address == `DPR_OFS_INIT_DATA;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			ack_q <= 1'b0;
		else
			ack_q <= (avs_read || avs_write) && !ack_q;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			ctrl_q <= `DPR_CTRL_RST;
			shift_q <= `DPR_SHIFT_RST;
			init_par_q <= '0;
		end
		else if (bus_wr)
		begin
			if (avs_address == `DPR_OFS_CTRL)
				ctrl_q <= be_merge(ctrl_q, avs_writedata, avs_byteenable);
			if (avs_address == `DPR_OFS_SHIFT)
				shift_q <= be_merge(shift_q, avs_writedata, avs_byteenable);
			if (avs_address == `DPR_OFS_INIT_PAR && avs_byteenable[0])
				init_par_q <= avs_writedata[3:0];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			init_addr_q <= '0;
		else if (bus_wr && avs_address == `DPR_OFS_INIT_ADDR && avs_byteenable[0])
			init_addr_q <= avs_writedata[6:0];
		else if (init_we)
			init_addr_q <= init_addr_q + 7'h01;
	end

	always_comb
	begin
		case (avs_address)
			`DPR_OFS_CTRL: rdata_d = ctrl_q;
			`DPR_OFS_SHIFT: rdata_d = shift_q;
			`DPR_OFS_STATUS: rdata_d = (32'(count_q) << `DPR_STAT_COUNT)
				| (32'(empty) << `DPR_STAT_EMPTY) | (32'(full) << `DPR_STAT_FULL)
				| (32'(cfg_err) << `DPR_STAT_ERR);
			`DPR_OFS_INIT_ADDR: rdata_d = 32'(init_addr_q);
			`DPR_OFS_INIT_DATA: rdata_d = mem_q[init_addr_q][31:0];
			`DPR_OFS_INIT_PAR: rdata_d = 32'(init_par_q);
			default: rdata_d = '0;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			rdata_q <= '0;
		else if (avs_read && !ack_q)
			rdata_q <= rdata_d;
	end

	// Port clock selection between the two block clocks
	assign ie_a = (ctrl_q[`DPR_CTRL_INSEL_A] ? clk1_en : clk0_en) && ce_a; // RULE13
	assign ie_b = (ctrl_q[`DPR_CTRL_INSEL_B] ? clk1_en : clk0_en) && ce_b; // RULE13
	assign oe_a = (ctrl_q[`DPR_CTRL_OUTSEL_A] ? clk1_en : clk0_en) && ce_a; // RULE13
	assign oe_b = (ctrl_q[`DPR_CTRL_OUTSEL_B] ? clk1_en : clk0_en) && ce_b; // RULE13

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			go_a_q <= 1'b0;
			go_b_q <= 1'b0;
			we_a_q <= 1'b0;
			we_b_q <= 1'b0;
			addr_a_q <= '0;
			addr_b_q <= '0;
			bm_a_q <= '0;
			bm_b_q <= '0;
			wd_a_q <= '0;
			wd_b_q <= '0;
		end
		else
		begin
			go_a_q <= ie_a; // RULE14
			go_b_q <= ie_b; // RULE14
			if (ie_a)
			begin
				we_a_q <= rdwr_a;
				addr_a_q <= addr_a;
				bm_a_q <= bmask_a;
				wd_a_q <= wdata_a;
			end
			if (ie_b)
			begin
				we_b_q <= rdwr_b;
				addr_b_q <= addr_b;
				bm_b_q <= bmask_b;
				wd_b_q <= wdata_b;
			end
		end
	end

	assign ea_a = mode == dpr_pkg::DPR_FIFO ? wptr_q
		: (mode == dpr_pkg::DPR_SHIFT ? sr_ptr_q : addr_a_q);
	assign ea_b = mode == dpr_pkg::DPR_FIFO ? rptr_q : addr_b_q;
	assign wa_a = word_of(wc_a, par_a, ea_a);
	assign wa_b = word_of(wc_b, par_b, ea_b);
	assign bea = wid_a >= `DPR_MASK_MIN_W ? bm_a_q : 4'hf; // RULE8
	assign beb = wid_b >= `DPR_MASK_MIN_W ? bm_b_q : 4'hf; // RULE8
	assign wm_a = wmask_of(wc_a, par_a, ea_a, bea);
	assign wm_b = wmask_of(wc_b, par_b, ea_b, beb);
	assign nw_a = (mem_q[wa_a] & ~wm_a) | (wval_of(wc_a, par_a, ea_a, wd_a_q) & wm_a); // RULE9
	assign nw_b = ((wr_a && wa_a == wa_b) ? nw_a : mem_q[wa_b]) & ~wm_b
		| (wval_of(wc_b, par_b, ea_b, wd_b_q) & wm_b); // RULE9
	assign rx_a = read_of(wc_a, par_a, ea_a, mem_q[wa_a]);
	assign rx_b = read_of(wc_b, par_b, ea_b, mem_q[wa_b]);

	assign wr_a = go_a_q && !cfg_err && (mode == dpr_pkg::DPR_SHIFT
		|| (we_a_q && (mode inside {dpr_pkg::DPR_TDP, dpr_pkg::DPR_SDP, dpr_pkg::DPR_SP}
		|| (mode == dpr_pkg::DPR_FIFO && !full)))); // RULE19
	assign wr_b = go_b_q && !cfg_err && we_b_q && mode == dpr_pkg::DPR_TDP; // RULE19
	assign rd_a_en = go_a_q && !cfg_err && !wr_a
		&& !(mode inside {dpr_pkg::DPR_FIFO, dpr_pkg::DPR_SHIFT}); // RULE19
	assign rd_b_en = go_b_q && !cfg_err && !wr_b && (mode == dpr_pkg::DPR_FIFO ? !empty
		: !(mode inside {dpr_pkg::DPR_SP, dpr_pkg::DPR_SHIFT}));

	// Port B writes last and already carries port A's bits for a shared word
	always_ff @(posedge mclk)
	begin
		if (init_we)
			mem_q[init_addr_q] <= {init_par_q, avs_writedata}; // RULE15
		if (wr_a)
			mem_q[wa_a] <= nw_a;
		if (wr_b)
			mem_q[wa_b] <= nw_b;
	end

	// FIFO pointers count in units of the port shape
	assign push = wr_a && mode == dpr_pkg::DPR_FIFO;
	assign pop = rd_b_en && mode == dpr_pkg::DPR_FIFO;
	assign full = int'(count_q) >= depth_a;
	assign empty = count_q == '0;

	always_ff @(posedge mclk)
	begin
		if (!rst_n || mode != dpr_pkg::DPR_FIFO)
		begin
			wptr_q <= '0;
			rptr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
				wptr_q <= int'(wptr_q) >= depth_a - 1 ? '0 : wptr_q + 12'h001;
			if (pop)
				rptr_q <= int'(rptr_q) >= depth_a - 1 ? '0 : rptr_q + 12'h001;
			count_q <= count_q + 13'(push) - 13'(pop);
		end
	end

	// Shift taps are read from the old contents before this cycle's write lands
	always_comb
	begin
		sr_taps = '0;
		ta = '0;
		tap_w = '0;
		for (int j = 0; j < `DPR_DATA_W; j++)
			if (j < tap_cnt && sr_len > 0)
			begin
				ta = 12'((int'(sr_ptr_q) + sr_len - (j + 1) * tap_len) % sr_len);
				tap_w = read_of(wc_a, par_a, ta, mem_q[word_of(wc_a, par_a, ta)]);
				for (int i = 0; i < `DPR_DATA_W; i++)
					if (i < wid_a && j * wid_a + i < `DPR_DATA_W)
						sr_taps[j * wid_a + i] = tap_w[i];
			end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n || mode != dpr_pkg::DPR_SHIFT)
			sr_ptr_q <= '0;
		else if (wr_a)
			sr_ptr_q <= int'(sr_ptr_q) >= sr_len - 1 ? '0 : sr_ptr_q + 12'h001; // RULE17
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n || clr_a)
			rd_a_q <= '0; // RULE20
		else if (rd_a_en)
			rd_a_q <= rx_a;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n || clr_b)
			rd_b_q <= '0; // RULE20
		else if (mode == dpr_pkg::DPR_SHIFT && wr_a)
			rd_b_q <= sr_taps; // RULE17
		else if (rd_b_en)
			rd_b_q <= rx_b;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n || clr_a)
			out_a_q <= '0; // RULE20
		else if (oe_a)
			out_a_q <= rd_a_q; // RULE13
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n || clr_b)
			out_b_q <= '0; // RULE20
		else if (oe_b)
			out_b_q <= rd_b_q; // RULE13
	end

	assign rdata_a = ctrl_q[`DPR_CTRL_BYP_A] ? rd_a_q : out_a_q; // RULE14
	assign rdata_b = ctrl_q[`DPR_CTRL_BYP_B] ? rd_b_q : out_b_q; // RULE14

	// Helper state for the masked-write check
	logic keep_chk_q;
	logic [6:0] keep_wa_q;
	dpr_pkg::dpr_word_t keep_m_q, keep_v_q;
	always_ff @(posedge mclk)
	begin
		keep_chk_q <= rst_n && wr_a && !wr_b && !init_we;
		keep_wa_q <= wa_a;
		keep_m_q <= wm_a;
		keep_v_q <= mem_q[wa_a] & ~wm_a;
	end

	sequence s_take_a;
		ie_a && rdwr_a && mode == dpr_pkg::DPR_SP && !cfg_err && !bus_wr;
	endsequence
	sequence s_commit_a;
		wr_a && wa_a == word_of(wc_a, par_a, addr_a_q);
	endsequence
	sequence s_shift_step;
		mode == dpr_pkg::DPR_SHIFT && wr_a && !clr_b;
	endsequence

	chk_bus_wait: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("bus answer late");
	chk_in_capture: assert property (ie_a |=> go_a_q && addr_a_q == $past(addr_a) // RULE14
		&& wd_a_q == $past(wdata_a)) else $error("port A inputs not registered");
	chk_take_write: assert property (s_take_a |=> s_commit_a) // RULE19
		else $error("enabled write not committed");
	chk_clear_zero: assert property (clr_a |=> out_a_q == '0 && rd_a_q == '0) // RULE20
		else $error("clear did not zero output");
	chk_rom_ro: assert property (mode == dpr_pkg::DPR_ROM |-> !wr_a && !wr_b) // RULE2
		else $error("write in read-only mode");
	chk_tdp_wide: assert property (mode == dpr_pkg::DPR_TDP // RULE4
		&& (wc_a == 3'h5 || wc_b == 3'h5) |-> cfg_err) else $error("wide shape in dual-port");
	chk_group_mix: assert property (mode inside {dpr_pkg::DPR_TDP, dpr_pkg::DPR_SDP} // RULE6
		&& par_a != par_b |-> cfg_err && !wr_a && !wr_b) else $error("group mix accepted");
	chk_sr_size: assert property (mode == dpr_pkg::DPR_SHIFT // RULE7
		&& wid_a * sr_len > `DPR_CAPACITY |-> !wr_a) else $error("shift register too large");
	chk_byte_keep: assert property (keep_chk_q // RULE9
		|-> (mem_q[keep_wa_q] & ~keep_m_q) == keep_v_q) else $error("masked byte changed");
	chk_narrow_mask: assert property (wr_a && wid_a < `DPR_MASK_MIN_W // RULE8
		|-> $countones(wm_a) == wid_a) else $error("mask on narrow write");
	chk_shift_old: assert property (s_shift_step |=> rd_b_q == $past(sr_taps)) // RULE17
		else $error("taps not read before write");
	chk_fifo_full: assert property (mode == dpr_pkg::DPR_FIFO && full |-> !wr_a)
		else $error("push into full buffer");
endmodule

/* File: dpr_fabric.sv */
// Fabric-side user logic model that drives one port of the memory block
`timescale 1ns/10ps
module dpr_fabric (
	input wire logic mclk,
	output logic ce,
	output logic rdwr,
	output logic clr,
	output logic [11:0] addr,
	output logic [3:0] bmask,
	output logic [35:0] wdata,
	input wire logic [35:0] rdata
);
	initial
	begin
		ce = 1'b0;
		rdwr = 1'b0;
		clr = 1'b0;
		addr = 12'h000;
		bmask = 4'h0;
		wdata = 36'h0;
	end

	// Released lines show the inverse of their last value, never a stale copy
	task automatic release_bus();
		ce <= 1'b0;
		rdwr <= ~rdwr;
		addr <= ~addr;
		bmask <= ~bmask;
		wdata <= ~wdata;
	endtask

	// One write access, then one edge for it to land
	task automatic put(input logic [11:0] a, input logic [3:0] m, input logic [35:0] d);
		@(posedge mclk);
		ce <= 1'b1;
		rdwr <= 1'b1;
		addr <= a;
		bmask <= m;
		wdata <= d;
		@(posedge mclk);
		release_bus();
		@(posedge mclk);
	endtask

	// Enable held over capture, read register and output register edges
	task automatic get(input logic [11:0] a, output logic [35:0] q);
		@(posedge mclk);
		ce <= 1'b1;
		rdwr <= 1'b0;
		addr <= a;
		repeat (3) @(posedge mclk);
		release_bus();
		@(negedge mclk);
		q = rdata;
	endtask

	task automatic wipe();
		@(posedge mclk);
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
	endtask
endmodule

/* File: tb_dual_port_block_ram_4k.sv */
// Self-checking testbench of the dual-port memory block
`timescale 1ns/10ps
module tb_dual_port_block_ram_4k;
	typedef struct packed {
		logic [31:0] ctrl;
		logic [11:0] addr;
		logic [3:0] mask;
		logic [35:0] wdata;
		logic [35:0] exp;
	} dpr_row_s;
	localparam int LIMIT = 5000;
	logic mclk;
	logic rst_n;
	logic [4:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic clk0_en;
	logic clk1_en;
	logic ce_a, rdwr_a, clr_a, ce_b, rdwr_b, clr_b;
	logic [11:0] addr_a, addr_b;
	logic [3:0] bmask_a, bmask_b;
	logic [35:0] wdata_a, rdata_a, wdata_b, rdata_b;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [31:0] q;
	logic [35:0] r;
	logic [31:0] cfg_ctrl [7] = '{32'h550, 32'h3c0, 32'hd51, 32'h351, 32'h551, 32'hcc0, 32'h6};
	logic cfg_err [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
	dpr_row_s rows [7] = '{
		'{32'hcc0, 12'h001, 4'h3, 36'h0_0002_a5a5, 36'h0_0002_a5a5},
		'{32'hcc0, 12'h001, 4'h1, 36'h0_0000_0000, 36'h0_0002_a400},
		'{32'hcc0, 12'h001, 4'h2, 36'h0_0003_ffff, 36'h0_0003_fe00},
		'{32'hcc0, 12'h001, 4'h0, 36'h0_0000_0000, 36'h0_0003_fe00},
		'{32'h440, 12'h009, 4'h3, 36'h0_0000_beef, 36'h0_0000_beef},
		'{32'h440, 12'h009, 4'h2, 36'h0_0000_1200, 36'h0_0000_12ef},
		'{32'h330, 12'h005, 4'h0, 36'h0_0000_00a5, 36'h0_0000_00a5}};

	dpr_ram dpr_ram_inst (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .clk0_en(clk0_en), .clk1_en(clk1_en),
		.ce_a(ce_a), .rdwr_a(rdwr_a), .clr_a(clr_a), .addr_a(addr_a), .bmask_a(bmask_a),
		.wdata_a(wdata_a), .rdata_a(rdata_a), .ce_b(ce_b), .rdwr_b(rdwr_b), .clr_b(clr_b),
		.addr_b(addr_b), .bmask_b(bmask_b), .wdata_b(wdata_b), .rdata_b(rdata_b));
	dpr_fabric dpr_fabric_inst (.mclk(mclk), .ce(ce_a), .rdwr(rdwr_a), .clr(clr_a),
		.addr(addr_a), .bmask(bmask_a), .wdata(wdata_a), .rdata(rdata_a));
	dpr_fabric dpr_fabric_b_inst (.mclk(mclk), .ce(ce_b), .rdwr(rdwr_b), .clr(clr_b),
		.addr(addr_b), .bmask(bmask_b), .wdata(wdata_b), .rdata(rdata_b));

	always #20 mclk = ~mclk;

	task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Request held until the edge where waitrequest is low
	task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		@(posedge mclk);
		avs_write <= wr;
		avs_read <= ~wr;
		avs_address <= a;
		avs_writedata <= d;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0)
		begin
			@(posedge mclk);
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles >= LIMIT)
		begin
			miscompares++;
			stop_test();
		end
	end

	initial
	begin
		mclk = 1'b0;
		rst_n = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_byteenable = 4'hf;
		avs_writedata = 32'h0;
		clk0_en = 1'b1;
		clk1_en = 1'b0;
		repeat (7) @(posedge mclk);
		@(negedge mclk);
		check("rdata_a reset", rdata_a, 36'h0);
		check("rdata_b reset", rdata_b, 36'h0);
		@(posedge mclk);
		rst_n <= 1'b1;
		av(1'b0, 5'h00, 32'h0, q);
		check("ctrl reset", {4'h0, q}, 36'h0);
		av(1'b0, 5'h04, 32'h0, q);
		check("shift reset", {4'h0, q}, 36'h0_0001_0001);
		av(1'b1, 5'h18, 32'hffff_ffff, q);
		av(1'b0, 5'h18, 32'h0, q);
		check("unmapped read", {4'h0, q}, 36'h0);
		av(1'b0, 5'h00, 32'h0, q);
		check("ctrl kept", {4'h0, q}, 36'h0);
		foreach (cfg_ctrl[i])
		begin
			av(1'b1, 5'h00, cfg_ctrl[i], q);
			av(1'b0, 5'h08, 32'h0, q);
			check("config error", {35'h0, q[0]}, {35'h0, cfg_err[i]});
		end
		foreach (rows[i])
		begin
			av(1'b1, 5'h00, rows[i].ctrl, q);
			dpr_fabric_inst.put(rows[i].addr, rows[i].mask, rows[i].wdata);
			dpr_fabric_inst.get(rows[i].addr, r);
			check("row read", r, rows[i].exp);
		end
		av(1'b1, 5'h00, 32'hcc0, q);
		dpr_fabric_b_inst.get(12'h001, r);
		check("port b read", r, 36'h0_0003_fe00);
		dpr_fabric_inst.get(12'h001, r);
		dpr_fabric_inst.wipe();
		@(negedge mclk);
		check("cleared output", rdata_a, 36'h0);
		dpr_fabric_inst.get(12'h001, r);
		check("memory after clear", r, 36'h0_0003_fe00);
		dpr_fabric_inst.put(12'h002, 4'h3, 36'h0_0002_2222);
		av(1'b1, 5'h00, 32'h1cc0, q);
		dpr_fabric_inst.put(12'h002, 4'h3, 36'h0_0001_1111);
		av(1'b1, 5'h00, 32'hcc0, q);
		dpr_fabric_inst.get(12'h002, r);
		check("idle input clock", r, 36'h0_0002_2222);
		av(1'b1, 5'h00, 32'h1cc0, q);
		clk1_en <= 1'b1;
		dpr_fabric_inst.put(12'h002, 4'h3, 36'h0_0001_1111);
		dpr_fabric_inst.get(12'h002, r);
		check("second input clock", r, 36'h0_0001_1111);
		av(1'b1, 5'h0c, 32'h3, q);
		av(1'b1, 5'h14, 32'hf, q);
		av(1'b1, 5'h10, 32'h89ab_cdef, q);
		av(1'b0, 5'h0c, 32'h0, q);
		check("init address step", {4'h0, q}, 36'h4);
		av(1'b1, 5'h00, 32'hdd4, q);
		dpr_fabric_inst.get(12'h003, r);
		check("preloaded word", r, 36'hf_89ab_cdef);
		dpr_fabric_inst.put(12'h003, 4'hf, 36'h0);
		dpr_fabric_inst.get(12'h003, r);
		check("read only word", r, 36'hf_89ab_cdef);
		av(1'b1, 5'h0c, 32'h7f, q);
		av(1'b1, 5'h10, 32'h0, q);
		av(1'b0, 5'h0c, 32'h0, q);
		check("init address wrap", {4'h0, q}, 36'h0);
		av(1'b1, 5'h00, 32'h442, q);
		dpr_fabric_inst.put(12'h005, 4'h3, 36'h0_0000_4242);
		dpr_fabric_b_inst.put(12'h005, 4'h3, 36'h0_0000_9999);
		dpr_fabric_inst.get(12'h005, r);
		check("single port word", r, 36'h0_0000_4242);
		// FIFO of 256 halfwords with the port B output register bypassed
		av(1'b1, 5'h00, 32'h2_0443, q);
		dpr_fabric_b_inst.put(12'h000, 4'h0, 36'h0);
		av(1'b0, 5'h08, 32'h0, q);
		check("fifo empty pop", {4'h0, q}, 36'h0_0000_0004);
		dpr_fabric_inst.put(12'h000, 4'h3, 36'h0_0000_1234);
		dpr_fabric_inst.put(12'h000, 4'h3, 36'h0_0000_5678);
		repeat (255) dpr_fabric_inst.put(12'h000, 4'h3, 36'h0);
		av(1'b0, 5'h08, 32'h0, q);
		check("fifo full", {4'h0, q}, 36'h0_0100_0002);
		dpr_fabric_b_inst.put(12'h000, 4'h0, 36'h0);
		@(negedge mclk);
		check("fifo first out", rdata_b, 36'h0_0000_1234);
		dpr_fabric_b_inst.put(12'h000, 4'h0, 36'h0);
		@(negedge mclk);
		check("fifo second out", rdata_b, 36'h0_0000_5678);
		av(1'b0, 5'h08, 32'h0, q);
		check("fifo count", {4'h0, q}, 36'h0_00fe_0000);
		// Byte-wide shift register, two taps of two
		av(1'b1, 5'h04, 32'h0002_0002, q);
		av(1'b1, 5'h00, 32'h2_0035, q);
		for (int k = 1; k <= 6; k++)
			dpr_fabric_inst.put(12'h000, 4'h0, 36'(k * 17));
		@(negedge mclk);
		check("shift taps", rdata_b, 36'h0_0000_2244);
		av(1'b1, 5'h04, 32'h0001_0241, q);
		av(1'b0, 5'h08, 32'h0, q);
		check("shift too large", {35'h0, q[0]}, 36'h1);
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		check("rdata_b in reset", rdata_b, 36'h0);
		@(posedge mclk);
		rst_n <= 1'b1;
		av(1'b0, 5'h00, 32'h0, q);
		check("ctrl after reset", {4'h0, q}, 36'h0);
		stop_test();
	end
endmodule
